// *** logic/vcf_pkg.sv ***
// constants and carrier types for the capability bank and field decoder
package vcf_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] VCF_IDX_TAG_CAP = 12'h48c;
  localparam logic [11:0] VCF_IDX_FUNC_CAP = 12'h491;
  localparam logic [11:0] VCF_ADDR_TAG_LO = 12'h230; // (48c*4)&fff low word
  localparam logic [31:0] VCF_ADDR_MUL = 32'h00000004;
  // own registers for configuration and decoder access
  localparam logic [15:0] VCF_OFF_CFG = 16'h2000;
  localparam logic [15:0] VCF_OFF_ENC = 16'h2004;
  localparam logic [15:0] VCF_OFF_RES = 16'h2008;
  // capability bit positions
  localparam int VCF_B_XONLY = 0;
  localparam int VCF_B_WALK4 = 6;
  localparam int VCF_B_UC = 8;
  localparam int VCF_B_WB = 14;
  localparam int VCF_B_2M = 16;
  localparam int VCF_B_1G = 17;
  localparam int VCF_B_TFLUSH = 20;
  localparam int VCF_B_AD = 21;
  localparam int VCF_B_ADVEXIT = 22;
  localparam int VCF_B_TF_SINGLE = 25;
  localparam int VCF_B_TF_ALL = 26;
  localparam int VCF_B_GFLUSH = 32;
  localparam int VCF_B_GF_ADDR = 40;
  localparam int VCF_B_GF_SINGLE = 41;
  localparam int VCF_B_GF_ALL = 42;
  localparam int VCF_B_GF_KEEPG = 43;
  // implemented bits mask; everything else reads 0
  localparam logic [63:0] VCF_TAG_CAP_MASK = 64'h00000f0106734141;
  // translation entry bits
  localparam int VCF_E_RD = 0;
  localparam int VCF_E_WR = 1;
  localparam int VCF_E_EX = 2;
  localparam int VCF_E_UEX = 10;
  // encoding fields
  localparam logic [1:0] VCF_W16 = 2'h0;
  localparam logic [1:0] VCF_T_CTL = 2'h0;
  localparam logic [1:0] VCF_T_GST = 2'h2;
  localparam logic [1:0] VCF_T_HST = 2'h3;
  localparam logic [8:0] VCF_I_TAG = 9'h000;
  localparam logic [8:0] VCF_I_NVEC = 9'h001;
  localparam logic [8:0] VCF_I_RIDX = 9'h002;
  localparam logic [8:0] VCF_I_GSEL_LAST = 9'h007;
  localparam logic [8:0] VCF_I_GINT = 9'h008;
  localparam logic [8:0] VCF_I_LOG = 9'h009;
  localparam logic [8:0] VCF_I_HSEL_LAST = 9'h006;
  // field identifiers reported by the decoder
  typedef enum logic [4:0] {
    VCF_F_NONE, VCF_F_TAG, VCF_F_NVEC, VCF_F_RIDX,
    VCF_F_G_ES, VCF_F_G_CS, VCF_F_G_SS, VCF_F_G_DS, VCF_F_G_FS, VCF_F_G_GS, VCF_F_G_LDTR, VCF_F_G_TR,
    VCF_F_GINT, VCF_F_LOG,
    VCF_F_H_ES, VCF_F_H_CS, VCF_F_H_SS, VCF_F_H_DS, VCF_F_H_FS, VCF_F_H_GS, VCF_F_H_TR
  } vcf_field_t;
  // supported execution controls
  typedef struct packed {
    logic tag_en;
    logic posted_int;
    logic ve_exc;
    logic virt_int;
    logic mod_log;
  } vcf_sup_t;
  // decoder result
  typedef struct packed {
    logic valid;
    logic [1:0] width;
    logic [1:0] ftype;
    logic [8:0] index;
    vcf_field_t field;
  } vcf_dec_t;
  // all block state
  typedef struct packed {
    logic [31:0] hrdata;
    logic dphase;
    logic dwrite;
    logic [15:0] daddr;
    logic [31:0] enc;
    vcf_dec_t dec;
    logic entry_fail;
    logic exec_ok;
  } vcf_state_t;
endpackage

// *** logic/vcf_capability_decode.sv ***
// capability bank, vm-entry check and field decoder with ahb-lite slave
`timescale 1ns/1ps
// Behaviour
// - tag capability bit 0 high only when execute-only entries are accepted
// - with mode execute on, read/write clear plus bit 10 also executes
// - bit 6 reports four-level walk support
// - bit 8 uncacheable and bit 14 write-back structure types
// - bit 16 allows 2-Mbyte directory pages, bit 17 1-Gbyte pages
// - bits 20, 25, 26 report translation flush and its types
// - bit 21 reports accessed and dirty flag maintenance
// - advanced exit information only when bit 22 reads one
// - bits 32, 40 to 43 report tag flush and its types
// - all reserved capability bits read zero
// - tag capability exists only with bit 63 and bit 33 or 37
// - entry fails when function bit set, enables on, capability bit zero
// - function capability exists only with bit 63 and bit 45
// - every component selected by a 32-bit encoding
// - bits 14:13 zero means a 16-bit field
// - 16-bit fields need bit 0 clear
// - bits 11:10 select control, guest or host type
// - bits 9:1 hold the index within width and type
// - control encodings 0, 2, 4 map to tag, vector, root index
// - guest 800..80e selectors, 810 interrupt status, 812 log index
// - host c00..c0c map to host selectors
// - optional fields decode only when their control is supported
// - bits 31:15 and bit 12 must be zero
module vcf_capability_decode
  import vcf_pkg::*;
#(
  parameter logic [63:0] TAG_CAP_VALUE = 64'h00000f0106734141,
  parameter logic [63:0] FUNC_CAP_VALUE = 64'h0000000000000001
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic primary_cap63,
  input wire logic secondary_cap33,
  input wire logic secondary_cap37,
  input wire logic secondary_cap45,
  input wire vcf_sup_t supported,
  input wire logic entry_check,
  input wire logic [63:0] func_controls,
  input wire logic act_secondary,
  input wire logic en_vm_func,
  input wire logic mode_exec,
  input wire logic [10:0] entry_bits,
  input wire logic viol_event,
  output logic entry_fail,
  output logic exec_ok,
  output logic adv_exit_info,
  output vcf_dec_t dec_out
);

  // ---------------------------------------------------------------
  // constant capability images
  // ---------------------------------------------------------------
  wire logic [63:0] tag_cap;
  logic [63:0] func_cap;
  logic tag_exists;
  logic func_exists;
  // presence gating of both registers
  assign tag_exists = primary_cap63 & (secondary_cap33 | secondary_cap37);
  assign func_exists = primary_cap63 & secondary_cap45;
  // per-bit image: reserved bits forced to zero whatever the parameter says,
  // so a bad override cannot report a capability the logic does not carry
  for (genvar b = 0; b < 64; b++) begin : g_cap_bit
    if (VCF_TAG_CAP_MASK[b]) begin : g_impl
      assign tag_cap[b] = tag_exists & TAG_CAP_VALUE[b];
    end else begin : g_resv
      assign tag_cap[b] = 1'b0;
    end
  end
  assign func_cap = func_exists ? FUNC_CAP_VALUE : 64'h0;

  // ---------------------------------------------------------------
  // field decode function, used on the software encoding write path
  // ---------------------------------------------------------------
  function automatic vcf_dec_t decode(input logic [31:0] e, input vcf_sup_t s);
    vcf_dec_t d;
    logic ok;
    d.width = e[14:13];
    d.ftype = e[11:10];
    d.index = e[9:1];
    d.field = VCF_F_NONE;
    ok = (e[31:15] == 17'h0) && !e[12] && !e[0];
    if (ok && d.width == VCF_W16) begin
      case (d.ftype)
        VCF_T_CTL: begin
          if (d.index == VCF_I_TAG && s.tag_en) d.field = VCF_F_TAG;
          else if (d.index == VCF_I_NVEC && s.posted_int) d.field = VCF_F_NVEC;
          else if (d.index == VCF_I_RIDX && s.ve_exc) d.field = VCF_F_RIDX;
        end
        VCF_T_GST: begin
          if (d.index <= VCF_I_GSEL_LAST) d.field = vcf_field_t'(5'(VCF_F_G_ES) + d.index[4:0]);
          else if (d.index == VCF_I_GINT && s.virt_int) d.field = VCF_F_GINT;
          else if (d.index == VCF_I_LOG && s.mod_log) d.field = VCF_F_LOG;
        end
        VCF_T_HST: begin
          if (d.index <= VCF_I_HSEL_LAST) d.field = vcf_field_t'(5'(VCF_F_H_ES) + d.index[4:0]);
        end
        default: d.field = VCF_F_NONE;
      endcase
    end
    d.valid = (d.field != VCF_F_NONE);
    return d;
  endfunction

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  vcf_state_t st;
  vcf_state_t next_st;
  logic [15:0] aoff;
  logic [31:0] tag_lo_addr;
  logic [31:0] tag_hi_addr;
  logic [31:0] fn_lo_addr;
  logic [31:0] fn_hi_addr;
  logic xonly;
  logic uexec;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic enc_wr;
  logic [31:0] enc_new;
  vcf_dec_t dec_new;
  logic fail_req;
  logic uex_req;

  // byte addresses of the 64-bit registers, low word then high word
  assign tag_lo_addr = 32'(VCF_IDX_TAG_CAP) * VCF_ADDR_MUL;
  assign tag_hi_addr = tag_lo_addr + 32'h4;
  assign fn_lo_addr = 32'(VCF_IDX_FUNC_CAP) * VCF_ADDR_MUL;
  assign fn_hi_addr = fn_lo_addr + 32'h4;
  assign aoff = haddr[15:0];
  // accepted address phase: word transfers only, others are ignored
  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
  // encoding write lands in its data phase
  assign enc_wr = st.dphase && st.dwrite && (st.daddr == VCF_OFF_ENC);
  assign enc_new = enc_wr ? hwdata : st.enc;
  assign dec_new = enc_wr ? decode(hwdata, supported) : st.dec;

  // entry permission classification
  assign xonly = !entry_bits[VCF_E_RD] && !entry_bits[VCF_E_WR] && entry_bits[VCF_E_EX] && tag_cap[VCF_B_XONLY];
  assign uex_req = !entry_bits[VCF_E_RD] && !entry_bits[VCF_E_WR] && entry_bits[VCF_E_UEX] && mode_exec;
  assign uexec = uex_req && tag_cap[VCF_B_XONLY];
  // function control bit set with both enables but not allowed
  assign fail_req = entry_check && act_secondary && en_vm_func && ((func_controls & ~func_cap) != 64'h0);

  // ---------------------------------------------------------------
  // register read selection
  // ---------------------------------------------------------------
  // chosen in the address phase so the word stands in its flop for the
  // whole data phase; encoding and result read through a write in flight
  function automatic logic [31:0] read_word(input logic [15:0] a);
    logic [31:0] w;
    w = 32'h0; // unmapped offsets read zero
    if ({16'h0, a} == tag_lo_addr) w = tag_cap[31:0];
    if ({16'h0, a} == tag_hi_addr) w = tag_cap[63:32];
    if ({16'h0, a} == fn_lo_addr) w = func_cap[31:0];
    if ({16'h0, a} == fn_hi_addr) w = func_cap[63:32];
    if (a == VCF_OFF_ENC) w = enc_new;
    if (a == VCF_OFF_RES) w = {dec_new.valid, 15'h0, 3'h0, dec_new.field, dec_new.width, dec_new.ftype, 4'h0};
    if (a == VCF_OFF_CFG) w = {27'h0, supported};
    return w;
  endfunction

  // registered read word comes from this
  always_comb begin
    rd_mux = read_word(aoff);
  end

  // next-state: bus slave, decoder register and entry check
  always_comb begin
    next_st = st;
    next_st.enc = enc_new;
    next_st.dec = dec_new;
    // writes elsewhere fall through: the capability words are read-only
    if (addr_ok && !hwrite) begin
      next_st.hrdata = rd_mux;
    end
    next_st.dphase = addr_ok;
    next_st.dwrite = hwrite;
    next_st.daddr = aoff;
    next_st.entry_fail = fail_req;
    next_st.exec_ok = xonly || uexec;
  end

  // single register for all state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign entry_fail = st.entry_fail;
  assign exec_ok = st.exec_ok;
  assign adv_exit_info = viol_event && tag_cap[VCF_B_ADVEXIT];
  assign dec_out = st.dec;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // one clock domain, so clock and reset are named once here
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // advanced exit information needs the capability bit
  chk_adv_exit_gate: assert property (
    adv_exit_info |-> tag_cap[VCF_B_ADVEXIT]
  ) else $error("advanced exit without capability");
  // and is given on every violation event while the bit is set
  chk_adv_exit_pass: assert property (
    viol_event && tag_cap[VCF_B_ADVEXIT] |-> adv_exit_info
  ) else $error("advanced exit missing");
  // reserved capability bits never read one
  chk_tag_reserved: assert property (
    (tag_cap & ~VCF_TAG_CAP_MASK) == 64'h0
  ) else $error("reserved capability bit set");
  // absent register reads as all zero
  chk_tag_exists: assert property (
    !tag_exists |-> tag_cap == 64'h0
  ) else $error("tag capability without support");
  // walk length bit
  chk_walk_bit: assert property (
    tag_exists |-> tag_cap[VCF_B_WALK4] == TAG_CAP_VALUE[VCF_B_WALK4]
  ) else $error("walk bit wrong");
  // structure memory types
  chk_mem_types: assert property (
    tag_exists |-> tag_cap[VCF_B_UC] == TAG_CAP_VALUE[VCF_B_UC] && tag_cap[VCF_B_WB] == TAG_CAP_VALUE[VCF_B_WB]
  ) else $error("memory type bits wrong");
  // large page sizes
  chk_page_sizes: assert property (
    tag_exists |-> tag_cap[VCF_B_2M] == TAG_CAP_VALUE[VCF_B_2M] && tag_cap[VCF_B_1G] == TAG_CAP_VALUE[VCF_B_1G]
  ) else $error("page size bits wrong");
  // translation flush types, bits 25 and 26
  chk_flush_types: assert property (
    tag_exists |-> tag_cap[VCF_B_TF_ALL:VCF_B_TF_SINGLE] == TAG_CAP_VALUE[VCF_B_TF_ALL:VCF_B_TF_SINGLE]
  ) else $error("flush type bits wrong");
  // accessed and dirty flags, plus the translation flush bit
  chk_dirty_flags: assert property (
    tag_exists |-> tag_cap[VCF_B_AD] == TAG_CAP_VALUE[VCF_B_AD] && tag_cap[VCF_B_TFLUSH] == TAG_CAP_VALUE[VCF_B_TFLUSH]
  ) else $error("dirty flag bit wrong");
  // tag flush and its four types
  chk_tag_flush: assert property (
    tag_exists |-> tag_cap[VCF_B_GF_KEEPG:VCF_B_GFLUSH] == TAG_CAP_VALUE[VCF_B_GF_KEEPG:VCF_B_GFLUSH]
  ) else $error("tag flush bits wrong");
  // absent function register reads as all zero
  chk_func_exists: assert property (
    !func_exists |-> func_cap == 64'h0
  ) else $error("function capability without support");
  // present function register shows its image
  chk_func_present: assert property (
    func_exists |-> func_cap == FUNC_CAP_VALUE
  ) else $error("function capability wrong");

  // an unallowed function control makes entry fail next cycle
  chk_entry_fail: assert property (
    disable iff (!hresetn || !clk_en) fail_req |=> entry_fail
  ) else $error("entry did not fail");
  // and entry fails for no other reason
  chk_entry_cause: assert property (
    disable iff (!hresetn || !clk_en) entry_fail |-> $past(fail_req)
  ) else $error("entry failed without cause");
  // execute-only needs the capability
  chk_exec_only: assert property (
    disable iff (!hresetn || !clk_en) exec_ok |-> $past(tag_cap[VCF_B_XONLY])
  ) else $error("execute accepted without capability");
  // execute-only needs data access clear
  chk_exec_perm: assert property (
    disable iff (!hresetn || !clk_en) exec_ok |-> $past(!entry_bits[VCF_E_RD] && !entry_bits[VCF_E_WR])
  ) else $error("execute accepted with data access");
  // execute-only entry is accepted
  chk_xonly_accept: assert property (
    disable iff (!hresetn || !clk_en) xonly |=> exec_ok
  ) else $error("execute-only entry refused");
  // mode execute entry is accepted
  chk_mode_exec: assert property (
    disable iff (!hresetn || !clk_en) uex_req && tag_cap[VCF_B_XONLY] |=> exec_ok
  ) else $error("mode execute entry refused");

  // slave never stalls and always answers okay
  chk_bus_okay: assert property (
    hreadyout && !hresp
  ) else $error("bus response not okay");
  // non-word transfers are not taken
  chk_size_refused: assert property (
    disable iff (!hresetn || !clk_en) hsel && htrans[1] && hsize != 3'h2 |=> !st.dphase
  ) else $error("non-word transfer taken");
  // capability low word reaches the data phase
  chk_read_word: assert property (
    disable iff (!hresetn || !clk_en) addr_ok && !hwrite && aoff == tag_lo_addr[15:0] |=> hrdata == $past(tag_cap[31:0])
  ) else $error("capability read wrong");
  // support word reads back
  chk_cfg_read: assert property (
    disable iff (!hresetn || !clk_en) addr_ok && !hwrite && aoff == VCF_OFF_CFG |=> hrdata == {27'h0, $past(supported)}
  ) else $error("support read wrong");
  // read data holds between reads
  chk_hrdata_hold: assert property (
    disable iff (!hresetn || !clk_en) !(addr_ok && !hwrite) |=> $stable(hrdata)
  ) else $error("read data moved");
  // encoding write lands
  chk_enc_write: assert property (
    disable iff (!hresetn || !clk_en) enc_wr |=> st.enc == $past(hwdata)
  ) else $error("encoding write lost");

  // result holds until the next encoding write
  chk_dec_hold: assert property (
    disable iff (!hresetn || !clk_en) !enc_wr |=> $stable(dec_out)
  ) else $error("decoder result moved");
  // reserved encoding bits clear
  chk_dec_reserved: assert property (
    dec_out.valid |-> (st.enc[31:15] == 17'h0 && !st.enc[12])
  ) else $error("bad encoding valid");
  // only the 16-bit width is decoded
  chk_dec_width: assert property (
    dec_out.valid |-> st.enc[14:13] == VCF_W16
  ) else $error("wrong width");
  // full access only
  chk_dec_even: assert property (
    dec_out.valid |-> !st.enc[0]
  ) else $error("odd encoding valid");
  // type from bits 11:10, never the unused type
  chk_dec_type: assert property (
    dec_out.valid |-> dec_out.ftype == st.enc[11:10] && dec_out.ftype != 2'h1
  ) else $error("wrong type");
  // index from bits 9:1
  chk_dec_index: assert property (
    dec_out.valid |-> dec_out.index == st.enc[9:1]
  ) else $error("wrong index");
  // control fields stop at the root index
  chk_ctl_map: assert property (
    dec_out.valid && dec_out.ftype == VCF_T_CTL |-> dec_out.index <= VCF_I_RIDX
  ) else $error("control index out of range");
  // guest fields stop at the log index
  chk_gst_map: assert property (
    dec_out.valid && dec_out.ftype == VCF_T_GST |-> dec_out.index <= VCF_I_LOG
  ) else $error("guest index out of range");
  // host fields stop at the last selector
  chk_hst_map: assert property (
    dec_out.valid && dec_out.ftype == VCF_T_HST |-> dec_out.index <= VCF_I_HSEL_LAST
  ) else $error("host index out of range");
  // optional fields: support sampled at the write that decodes them
  chk_opt_tag: assert property (
    disable iff (!hresetn || !clk_en) enc_wr && !supported.tag_en |=> dec_out.field != VCF_F_TAG
  ) else $error("tag field without support");
  chk_opt_nvec: assert property (
    disable iff (!hresetn || !clk_en) enc_wr && !supported.posted_int |=> dec_out.field != VCF_F_NVEC
  ) else $error("vector field without support");
  chk_opt_ridx: assert property (
    disable iff (!hresetn || !clk_en) enc_wr && !supported.ve_exc |=> dec_out.field != VCF_F_RIDX
  ) else $error("root index field without support");
  chk_opt_gint: assert property (
    disable iff (!hresetn || !clk_en) enc_wr && !supported.virt_int |=> dec_out.field != VCF_F_GINT
  ) else $error("interrupt status field without support");
  chk_opt_log: assert property (
    disable iff (!hresetn || !clk_en) enc_wr && !supported.mod_log |=> dec_out.field != VCF_F_LOG
  ) else $error("log index field without support");
  // invalid result names no field
  chk_dec_none: assert property (
    !dec_out.valid |-> dec_out.field == VCF_F_NONE
  ) else $error("invalid result names a field");

  // main scenarios
  cov_decode_ok: cover property (dec_out.valid);
  cov_decode_bad: cover property (st.enc != 32'h0 && !dec_out.valid);
  cov_entry_fail: cover property (entry_fail);
  cov_exec_ok: cover property (exec_ok);
  cov_adv_exit: cover property (adv_exit_info);
endmodule

// *** bench/vcf_exec_model.sv ***
// execution and vm-entry side model driving the check inputs
`timescale 1ns/1ps
// ----------------------------------------
// far-side request generator
// ----------------------------------------
module vcf_exec_model
  import vcf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] rnd,
  output logic entry_check,
  output logic [63:0] func_controls,
  output logic act_secondary,
  output logic en_vm_func,
  output logic mode_exec,
  output logic [10:0] entry_bits,
  output logic viol_event
);
  logic [1:0] hold;
  // holds each request 1 to 4 cycles so quick and slow callers both appear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {entry_check, func_controls, act_secondary, en_vm_func, mode_exec, entry_bits, viol_event} <= '0;
      hold <= 2'h0;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      entry_check <= rnd[0];
      act_secondary <= rnd[1];
      en_vm_func <= rnd[2];
      func_controls <= {60'h0, rnd[6:3]};
      mode_exec <= rnd[7];
      entry_bits <= rnd[18:8];
      viol_event <= rnd[19];
      hold <= rnd[31:30];
    end
  end
endmodule

// *** bench/vcf_capability_decode_tb.sv ***
// self-checking bench for the capability bank and field decoder
`timescale 1ns/1ps
// ----------------------------------------
// bench top
// ----------------------------------------
module vcf_capability_decode_tb;
  import vcf_pkg::*;
  localparam logic [63:0] TCAP = 64'h00000f0106734141;
  localparam logic [63:0] FCAP = 64'h0000000000000005;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, chk_on = 1'b0, e_fail = 1'b0, e_ok = 1'b0;
  logic p63 = 1'b1, s33 = 1'b1, s37 = 1'b1, s45 = 1'b1;
  logic [31:0] haddr = '0, hwdata = '0, rnd = 32'haa82, r, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hresp, ent_chk, act_sec, en_vmf, mode_exec, viol, entry_fail, exec_ok, adv_exit;
  logic [63:0] func_ctl;
  logic [10:0] ebits;
  vcf_sup_t sup = '0;
  vcf_dec_t dec_out, d;
  logic [31:0] d_bad [6] = '{32'h801, 32'h1000, 32'h8000, 32'h2000, 32'h400, 32'h814};
  int n_fail = 0, n_tests = 0;
  always #2.5 hclk = ~hclk;
  vcf_capability_decode #(.TAG_CAP_VALUE(TCAP), .FUNC_CAP_VALUE(FCAP)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .primary_cap63(p63), .secondary_cap33(s33),
    .secondary_cap37(s37), .secondary_cap45(s45), .supported(sup), .entry_check(ent_chk), .func_controls(func_ctl),
    .act_secondary(act_sec), .en_vm_func(en_vmf), .mode_exec(mode_exec), .entry_bits(ebits), .viol_event(viol),
    .entry_fail(entry_fail), .exec_ok(exec_ok), .adv_exit_info(adv_exit), .dec_out(dec_out));
  vcf_exec_model part_u (.hclk(hclk), .hresetn(hresetn), .rnd(rnd), .entry_check(ent_chk), .func_controls(func_ctl),
    .act_secondary(act_sec), .en_vm_func(en_vmf), .mode_exec(mode_exec), .entry_bits(ebits), .viol_event(viol));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // reference decoder built from the encoding layout
  function automatic vcf_dec_t dmodel(logic [31:0] e, vcf_sup_t s);
    vcf_dec_t m;
    int i;
    m = '0;
    i = e[9:1];
    m.width = e[14:13];
    m.ftype = e[11:10];
    m.index = e[9:1];
    case (e[11:10])
      VCF_T_CTL: m.field = (i == 0 && s.tag_en) ? VCF_F_TAG : (i == 1 && s.posted_int) ? VCF_F_NVEC :
        (i == 2 && s.ve_exc) ? VCF_F_RIDX : VCF_F_NONE;
      VCF_T_GST: m.field = (i < 8) ? vcf_field_t'(VCF_F_G_ES + i) : (i == 8 && s.virt_int) ? VCF_F_GINT :
        (i == 9 && s.mod_log) ? VCF_F_LOG : VCF_F_NONE;
      VCF_T_HST: m.field = (i < 7) ? vcf_field_t'(VCF_F_H_ES + i) : VCF_F_NONE;
      default: m.field = VCF_F_NONE;
    endcase
    m.valid = e[31:15] == 0 && !e[12] && !e[0] && e[14:13] == VCF_W16 && m.field != VCF_F_NONE;
    return m;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask
  // one encoding through the decoder, then read back
  task automatic dec(input logic [31:0] e);
    sup <= vcf_sup_t'(rnd[4:0]);
    xfer(1'b1, 32'h2004, e, r);
    @(posedge hclk);
    #1 d = dmodel(e, sup);
    if (d.valid) check(dec_out, d);
    else check(dec_out.valid, 1'b0);
    xfer(1'b0, 32'h2004, 32'h0, r);
    check(r, e);
    xfer(1'b0, 32'h2008, 32'h0, r);
    check(r[31], d.valid);
  endtask
  // random stimulus and per-cycle entry expectations
  always @(posedge hclk) begin
    rnd <= lfsr(rnd);
    e_fail <= ent_chk & act_sec & en_vmf & |(func_ctl & ~FCAP);
    e_ok <= !ebits[0] & !ebits[1] & (ebits[2] | mode_exec & ebits[10]) & TCAP[0];
    if (chk_on) begin
      check(entry_fail, e_fail);
      check(exec_ok, e_ok);
    end
  end
  always @(negedge hclk) if (chk_on) check(adv_exit, viol & TCAP[22]);
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 32'h1234, 32'h0, r);
    check(r, TCAP[63:32] & VCF_TAG_CAP_MASK[63:32]);
    for (int k = 0; k < 16; k++) begin
      {p63, s33, s37, s45} <= 4'(k);
      xfer(1'b0, 32'h1230, 32'h0, r);
      check(r, (k[3] & (k[2] | k[1])) ? TCAP[31:0] & VCF_TAG_CAP_MASK[31:0] : 32'h0);
      xfer(1'b0, 32'h1244, 32'h0, r);
      check(r, (k[3] & k[0]) ? FCAP[31:0] : 32'h0);
    end
    // read-only write ignored, unmapped read gives zero
    xfer(1'b1, 32'h1230, 32'h0, r);
    xfer(1'b0, 32'h1230, 32'h0, r);
    check(r, TCAP[31:0]);
    xfer(1'b0, 32'h3000, 32'h0, r);
    check(r, 32'h0);
    chk_on <= 1'b1;
    for (int t = 0; t < 3; t++)
      for (int i = 0; i < 11; i++) dec(32'(t == 0 ? 0 : t == 1 ? 32'h800 : 32'hc00) + 32'(2 * i));
    foreach (d_bad[j]) dec(d_bad[j]);
    repeat (40) dec(rnd & 32'h00009c1f);
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge hclk);
    n_fail++;
    complete_run();
  end
endmodule
